// [core/bsfl_defines.svh]
`ifndef BSFL_DEFINES_SVH
`define BSFL_DEFINES_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define BSFL_CLK_MHZ          40
// Debounce 8.0 ms, held in tenths of a millisecond
`define BSFL_DEB_TIME_MS_X10  80
`define BSFL_DEB_CYCLES       (`BSFL_DEB_TIME_MS_X10 * `BSFL_CLK_MHZ * 100)
// Ramp step intervals 2.0 us and 4.0 us, held in nanoseconds
`define BSFL_STEP_FAST_NS     2000
`define BSFL_STEP_SLOW_NS     4000
`define BSFL_STEP_FAST_CYC    (`BSFL_STEP_FAST_NS * `BSFL_CLK_MHZ / 1000)
`define BSFL_STEP_SLOW_CYC    (`BSFL_STEP_SLOW_NS * `BSFL_CLK_MHZ / 1000)

// ----------------------------------------------------------------
// Voltage codes, in units of 12.5 mV
// ----------------------------------------------------------------
`define BSFL_TRK_BASE         9'h030
`define BSFL_FIX_V0           9'h058
`define BSFL_FIX_V1           9'h060
`define BSFL_FIX_V2           9'h06c
`define BSFL_FIX_V3           9'h078
`define BSFL_FIX_V4           9'h090
`define BSFL_FIX_V5           9'h0c8
`define BSFL_FIX_V6           9'h0f0
`define BSFL_FIX_VMAX         9'h108

// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define BSFL_SP_W             6
`define BSFL_VC_W             9
`define BSFL_SP_RST           6'h00
`define BSFL_VC_RST           9'h000

`endif

// [core/bsfl_pkg.sv]
`include "bsfl_defines.svh"

package bsfl_pkg;
    // Operating state of the power controller, supplied by the sequencer
    typedef enum logic [1:0] {
        st_off,
        st_run,
        st_standby,
        st_sleep
    } bsfl_pmic_state_t;

    // Setpoint field selector for host writes
    typedef enum logic [1:0] {
        sel_run,
        sel_standby,
        sel_sleep,
        sel_none
    } bsfl_sel_t;

    typedef logic [`BSFL_SP_W-1:0] bsfl_sp_t;
    typedef logic [`BSFL_VC_W-1:0] bsfl_vc_t;
endpackage

// [core/bsfl_ilim_if.sv]
// Current-limit signals shared by the top and the limiter; index 0 high side, 1 low side
interface bsfl_ilim_if;
    logic [1:0] raw;
    logic       cycle_start;
    logic [1:0] status_clr;
    logic [1:0] sense;
    logic [1:0] status;
    logic [1:0] cut;

    modport lim (
        input  raw,
        input  cycle_start,
        input  status_clr,
        output sense,
        output status,
        output cut
    );

    modport ctl (
        output raw,
        output cycle_start,
        output status_clr,
        input  sense,
        input  status,
        input  cut
    );
endinterface

// [core/bsfl_ilim.sv]
`include "bsfl_defines.svh"

module bsfl_ilim
    import bsfl_pkg::*;
#(
    parameter int unsigned DEB_CYCLES = `BSFL_DEB_CYCLES
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // Limiter side of the current-limit carrier
    bsfl_ilim_if.lim  lim
);
    // ----------------------------------------------------------------
    // One identical limiter per switch
    // ----------------------------------------------------------------
    localparam logic [23:0] DEB_LAST = 24'(DEB_CYCLES);

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_side
            logic [2:0]  sync_ff;
            logic        filt_ff;
            logic        cut_ff;
            logic        stat_ff;
            logic [23:0] deb_cnt_ff;

            // Comparator is asynchronous; stage 0 only feeds stage 1
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    sync_ff <= 3'h0;
                end else begin
                    sync_ff <= {sync_ff[1:0], lim.raw[gi]};
                end
            end

            // A change counts once stages 1 and 2 agree
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    filt_ff <= 1'b0;
                end else if (sync_ff[1] == sync_ff[2]) begin
                    filt_ff <= sync_ff[2];
                end
            end

            // Switch held off for the rest of the switching cycle; a hit wins
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    cut_ff <= 1'b0;
                end else if (filt_ff) begin
                    cut_ff <= 1'b1;
                end else if (lim.cycle_start) begin
                    cut_ff <= 1'b0;
                end
            end

            // Continuous-fault timer, restarts on any gap, saturates
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    deb_cnt_ff <= 24'h000000;
                end else if (!filt_ff) begin
                    deb_cnt_ff <= 24'h000000;
                end else if (deb_cnt_ff != DEB_LAST) begin
                    deb_cnt_ff <= deb_cnt_ff + 24'h000001;
                end
            end

            // Sticky status; a fault past its debounce in the clear cycle keeps it set
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    stat_ff <= 1'b0;
                end else if (filt_ff && deb_cnt_ff == DEB_LAST) begin
                    stat_ff <= 1'b1;
                end else if (lim.status_clr[gi]) begin
                    stat_ff <= 1'b0;
                end
            end

            assign lim.sense[gi]  = filt_ff;
            assign lim.cut[gi]    = cut_ff;
            assign lim.status[gi] = stat_ff;
        end
    endgenerate
endmodule

// [core/bsfl_top.sv]
`include "bsfl_defines.svh"

module bsfl_top
    import bsfl_pkg::*;
#(
    parameter int unsigned DEB_CYCLES = `BSFL_DEB_CYCLES
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    // Sequencer and one-time-programmed configuration
    input  var  bsfl_pmic_state_t pmic_state,
    input  wire logic [5:0]       programmed_default_setpoint,
    input  wire logic             tracking_mode_select,
    input  wire logic             processor_reset_out_n,
    // Host setpoint access
    input  wire logic             host_wr_en,
    input  var  bsfl_sel_t        host_wr_sel,
    input  wire logic [5:0]       host_wr_data,
    input  wire logic             transition_speed_bit,
    output logic                  host_wr_refused,
    output logic [5:0]            run_setpoint,
    output logic [5:0]            standby_setpoint,
    output logic [5:0]            sleep_setpoint,
    // Regulator reference, in 12.5 mV units
    output logic [8:0]            target_code,
    output logic [8:0]            ref_code,
    output logic                  ramp_busy,
    // Current limit
    input  wire logic             hs_ilim_raw,
    input  wire logic             ls_ilim_raw,
    input  wire logic             switch_cycle_start,
    input  wire logic             hs_status_clr,
    input  wire logic             ls_status_clr,
    output logic                  hs_switch_off,
    output logic                  ls_switch_off,
    output logic                  hs_ilim_sense,
    output logic                  ls_ilim_sense,
    output logic                  hs_ilim_status,
    output logic                  ls_ilim_status
);
    // ----------------------------------------------------------------
    // Constants
    // ----------------------------------------------------------------
    localparam logic [7:0] STEP_FAST = 8'(`BSFL_STEP_FAST_CYC);
    localparam logic [7:0] STEP_SLOW = 8'(`BSFL_STEP_SLOW_CYC);

    // ----------------------------------------------------------------
    // Current-limit protection
    // ----------------------------------------------------------------
    bsfl_ilim_if ilim_bus ();

    assign ilim_bus.raw         = {ls_ilim_raw, hs_ilim_raw};
    assign ilim_bus.cycle_start = switch_cycle_start;
    assign ilim_bus.status_clr  = {ls_status_clr, hs_status_clr};

    bsfl_ilim #(
        .DEB_CYCLES (DEB_CYCLES)
    ) u_ilim (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .lim     (ilim_bus.lim)
    );

    // Limiter outputs come straight from its flops
    assign hs_switch_off  = ilim_bus.cut[0];
    assign ls_switch_off  = ilim_bus.cut[1];
    assign hs_ilim_sense  = ilim_bus.sense[0];
    assign ls_ilim_sense  = ilim_bus.sense[1];
    assign hs_ilim_status = ilim_bus.status[0];
    assign ls_ilim_status = ilim_bus.status[1];

    // ----------------------------------------------------------------
    // Startup detection
    // ----------------------------------------------------------------
    bsfl_pmic_state_t prev_state_ff;
    logic             startup;
    logic             startup_d_ff;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prev_state_ff <= st_off;
        end else begin
            prev_state_ff <= pmic_state;
        end
    end

    assign startup = (prev_state_ff == st_off) && (pmic_state == st_run);

    // Delayed startup marks the cycle the freshly loaded fields are visible
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            startup_d_ff <= 1'b0;
        end else begin
            startup_d_ff <= startup;
        end
    end

    // ----------------------------------------------------------------
    // Setpoint fields
    // ----------------------------------------------------------------
    bsfl_sp_t sp_ff [3];
    logic     wr_ok;
    logic     refused_ff;

    // Write gate: tracking_mode_select low, processor out of reset, a real field
    assign wr_ok = host_wr_en && !tracking_mode_select && processor_reset_out_n
                   && (host_wr_sel != sel_none);

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sp
            // Startup copy beats a host write in the same cycle
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    sp_ff[gi] <= `BSFL_SP_RST;
                end else if (startup) begin
                    sp_ff[gi] <= programmed_default_setpoint;
                end else if (wr_ok && host_wr_sel == bsfl_sel_t'(gi)) begin
                    sp_ff[gi] <= host_wr_data;
                end
            end
        end
    endgenerate

    // Flag writes that the field protection dropped, for host visibility
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            refused_ff <= 1'b0;
        end else begin
            refused_ff <= host_wr_en && (!wr_ok || startup);
        end
    end

    assign host_wr_refused  = refused_ff;
    assign run_setpoint     = sp_ff[0];
    assign standby_setpoint = sp_ff[1];
    assign sleep_setpoint   = sp_ff[2];

    // ----------------------------------------------------------------
    // Code decode
    // ----------------------------------------------------------------
    // Fixed-reference list is short, so a case beats a table memory
    function automatic bsfl_vc_t decode(input bsfl_sp_t code, input logic fixed_ref);
        bsfl_vc_t v;
        v = `BSFL_FIX_VMAX;
        if (!fixed_ref) begin
            v = `BSFL_TRK_BASE + {3'h0, code};
        end else begin
            case (code)
                6'h00:   v = `BSFL_FIX_V0;
                6'h01:   v = `BSFL_FIX_V1;
                6'h02:   v = `BSFL_FIX_V2;
                6'h03:   v = `BSFL_FIX_V3;
                6'h04:   v = `BSFL_FIX_V4;
                6'h05:   v = `BSFL_FIX_V5;
                6'h06:   v = `BSFL_FIX_V6;
                default: v = `BSFL_FIX_VMAX;
            endcase
        end
        return v;
    endfunction

    // Pick the field for the present state; off keeps the run field
    bsfl_sp_t active_sp;

    always_comb begin
        case (pmic_state)
            st_standby: active_sp = sp_ff[1];
            st_sleep:   active_sp = sp_ff[2];
            default:    active_sp = sp_ff[0];
        endcase
    end

    bsfl_vc_t nxt_target;
    bsfl_vc_t target_ff;

    assign nxt_target = decode(active_sp, tracking_mode_select);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            target_ff <= `BSFL_VC_RST;
        end else begin
            target_ff <= nxt_target;
        end
    end

    assign target_code = target_ff;

    // ----------------------------------------------------------------
    // Reference ramp
    // ----------------------------------------------------------------
    bsfl_vc_t   ref_ff;
    logic [7:0] tick_cnt_ff;
    logic [7:0] step_last;
    logic       step_now;

    assign step_last = transition_speed_bit ? (STEP_SLOW - 8'h01) : (STEP_FAST - 8'h01);
    assign step_now  = (tick_cnt_ff >= step_last);

    // Interval counter runs only while a move is pending
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_ff <= 8'h00;
        end else if (pmic_state == st_off || ref_ff == target_ff || step_now) begin
            tick_cnt_ff <= 8'h00;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 8'h01;
        end
    end

    // Startup lands on the loaded value directly; later changes ramp
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ref_ff <= `BSFL_VC_RST;
        end else if (pmic_state == st_off) begin
            ref_ff <= `BSFL_VC_RST;
        end else if (startup_d_ff) begin
            ref_ff <= nxt_target;
        end else if (step_now && ref_ff < target_ff) begin
            ref_ff <= ref_ff + 9'h001;
        end else if (step_now && ref_ff > target_ff) begin
            ref_ff <= ref_ff - 9'h001;
        end
    end

    assign ref_code  = ref_ff;
    assign ramp_busy = (pmic_state != st_off) && (ref_ff != target_ff);
endmodule

// [verif/bsfl_top_asserts.sv]
module bsfl_top_asserts
    import bsfl_pkg::*;
#(
    parameter int unsigned DEB_CYCLES = 20
) (
    // Clock, reset and configuration
    input wire logic             clk_sys,
    input wire logic             rst_n,
    input var  bsfl_pmic_state_t pmic_state,
    input wire logic [5:0]       programmed_default_setpoint,
    input wire logic             tracking_mode_select,
    input wire logic             processor_reset_out_n,
    input wire logic             transition_speed_bit,
    // Host write path
    input wire logic             host_wr_en,
    input var  bsfl_sel_t        host_wr_sel,
    input wire logic [5:0]       host_wr_data,
    input wire logic             host_wr_refused,
    input wire logic [5:0]       run_setpoint,
    input wire logic [5:0]       standby_setpoint,
    input wire logic [5:0]       sleep_setpoint,
    // Reference and current limit
    input wire logic [8:0]       target_code,
    input wire logic [8:0]       ref_code,
    input wire logic             hs_ilim_sense,
    input wire logic             hs_switch_off,
    input wire logic             hs_ilim_status,
    input wire logic             hs_status_clr
);
    timeunit 1ns;
    timeprecision 1ps;

    // Fixed references in 12.5 mV units; code 7 and above share the top one
    localparam logic [8:0] FIX [8] = '{9'h058, 9'h060, 9'h06c, 9'h078,
                                       9'h090, 9'h0c8, 9'h0f0, 9'h108};
    bsfl_pmic_state_t prev_ff;
    logic             su;
    logic [8:0]       gap_ff;
    int unsigned      run_ff;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // Startup edge, seen as the sequencer sees it
    assign su = (prev_ff == st_off) && (pmic_state == st_run);

    // Previous state and cycles since the reference last moved (saturating)
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prev_ff <= st_off;
            gap_ff  <= 9'h000;
        end else begin
            prev_ff <= pmic_state;
            gap_ff  <= $changed(ref_code) ? 9'h000 : gap_ff + {8'h00, gap_ff != 9'h1ff};
        end
    end

    // Consecutive high-side sense cycles; saturates so a long fault cannot wrap
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            run_ff <= 32'h0;
        end else begin
            run_ff <= !hs_ilim_sense ? 32'h0 : run_ff + 32'(run_ff != DEB_CYCLES);
        end
    end

    wr_take_a: assert property (
        host_wr_en && !tracking_mode_select && processor_reset_out_n && !su
        && host_wr_sel == sel_sleep |=> sleep_setpoint == $past(host_wr_data))
        else $error("sleep write not taken");
    wr_refuse_a: assert property (
        host_wr_en && (tracking_mode_select || !processor_reset_out_n
        || host_wr_sel == sel_none) |=> host_wr_refused)
        else $error("dropped write not flagged");
    wr_ro_a: assert property (
        tracking_mode_select && !su |=> $stable({run_setpoint, standby_setpoint, sleep_setpoint}))
        else $error("read-only field changed");
    startup_a: assert property (
        su |=> {run_setpoint, standby_setpoint, sleep_setpoint}
        == {3{$past(programmed_default_setpoint)}})
        else $error("startup copy wrong");
    dec_fix_a: assert property (
        pmic_state == st_sleep && tracking_mode_select |=> target_code
        == FIX[($past(sleep_setpoint) > 6'h06) ? 3'h7 : $past(sleep_setpoint[2:0])])
        else $error("fixed decode wrong");
    ramp_gap_a: assert property (
        $changed(ref_code) && $past(ref_code) != 9'h000 && ref_code != 9'h000
        |-> gap_ff >= ($past(transition_speed_bit) ? 9'h09f : 9'h04f))
        else $error("ramp step too early");
    cut_on_a: assert property (
        hs_ilim_sense |=> hs_switch_off)
        else $error("switch not cut on limit");
    status_set_a: assert property (
        hs_ilim_sense && run_ff == DEB_CYCLES |=> $rose(hs_ilim_status) || hs_ilim_status)
        else $error("status not set after debounce");
    status_hold_a: assert property (
        hs_ilim_status && !hs_status_clr |=> hs_ilim_status)
        else $error("status dropped without clear");
    status_early_a: assert property (
        $rose(hs_ilim_status) |-> $past(hs_ilim_sense) && $past(run_ff) == DEB_CYCLES)
        else $error("status set before debounce ran out");

    // Main scenarios
    startup_c: cover property (su);
    ramp_done_c: cover property ($changed(ref_code) && gap_ff > 9'h09e);
    status_c: cover property ($rose(hs_ilim_status));
endmodule

bind bsfl_top bsfl_top_asserts #(.DEB_CYCLES(DEB_CYCLES)) u_asserts (
    .clk_sys, .rst_n, .pmic_state, .programmed_default_setpoint, .tracking_mode_select,
    .processor_reset_out_n, .transition_speed_bit, .host_wr_en, .host_wr_sel, .host_wr_data,
    .host_wr_refused, .run_setpoint, .standby_setpoint, .sleep_setpoint, .target_code,
    .ref_code, .hs_ilim_sense, .hs_switch_off, .hs_ilim_status, .hs_status_clr
);

// [verif/bsfl_host.sv]
module bsfl_host
    import bsfl_pkg::*;
(
    // Clock and mode
    input  wire logic  clk_sys,
    input  wire logic  tracking_mode_select,
    // Write strobe towards the setpoint fields
    output logic       host_wr_en,
    output bsfl_sel_t  host_wr_sel,
    output logic [5:0] host_wr_data
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus at time zero
    initial begin
        host_wr_en = 1'b0;
        host_wr_sel = sel_none;
        host_wr_data = 6'h00;
    end

    // One-cycle write; a host never writes read-only fields
    task automatic wr(input bsfl_sel_t sel, input logic [5:0] data);
        @(posedge clk_sys);
        if (!tracking_mode_select) begin
            host_wr_en <= 1'b1;
            host_wr_sel <= sel;
            host_wr_data <= data;
            @(posedge clk_sys);
            host_wr_en <= 1'b0;
            host_wr_data <= ~data;
        end
        #1;
    endtask
endmodule

// [verif/bsfl_top_tb.sv]
module bsfl_top_tb
    import bsfl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned DEB = 20;
    logic             clk_sys, rst_n, tracking_mode_select, processor_reset_out_n;
    logic             transition_speed_bit, hs_ilim_raw, ls_ilim_raw, switch_cycle_start;
    logic             hs_status_clr, ls_status_clr, host_wr_en, host_wr_refused, ramp_busy;
    logic             hs_switch_off, ls_switch_off, hs_ilim_sense, ls_ilim_sense;
    logic             hs_ilim_status, ls_ilim_status, trk;
    logic [5:0]       programmed_default_setpoint, host_wr_data, code;
    logic [5:0]       run_setpoint, standby_setpoint, sleep_setpoint;
    logic [8:0]       target_code, ref_code, exp_v;
    bsfl_pmic_state_t pmic_state;
    bsfl_sel_t        host_wr_sel;
    int               num_errors = 0;
    int               checked = 0;
    // Mode, default code and the reference it should decode to
    logic [15:0]      rows [12] = '{{1'b1, 6'h00, 9'h058}, {1'b1, 6'h01, 9'h060},
        {1'b1, 6'h02, 9'h06c}, {1'b1, 6'h03, 9'h078}, {1'b1, 6'h04, 9'h090},
        {1'b1, 6'h05, 9'h0c8}, {1'b1, 6'h06, 9'h0f0}, {1'b1, 6'h07, 9'h108},
        {1'b1, 6'h3f, 9'h108}, {1'b0, 6'h00, 9'h030}, {1'b0, 6'h22, 9'h052},
        {1'b0, 6'h3f, 9'h06f}};

    bsfl_top #(.DEB_CYCLES(DEB)) dut (.clk_sys, .rst_n, .pmic_state,
        .programmed_default_setpoint, .tracking_mode_select, .processor_reset_out_n,
        .host_wr_en, .host_wr_sel, .host_wr_data, .transition_speed_bit, .host_wr_refused,
        .run_setpoint, .standby_setpoint, .sleep_setpoint, .target_code, .ref_code,
        .ramp_busy, .hs_ilim_raw, .ls_ilim_raw, .switch_cycle_start, .hs_status_clr,
        .ls_status_clr, .hs_switch_off, .ls_switch_off, .hs_ilim_sense, .ls_ilim_sense,
        .hs_ilim_status, .ls_ilim_status);
    bsfl_host u_host (.clk_sys, .tracking_mode_select, .host_wr_en, .host_wr_sel,
        .host_wr_data);

    // 40 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Let n edges pass, then look once their updates have landed
    task automatic pass(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // Power up from off; off is held two cycles so the startup edge is clean
    task automatic start(input logic t, input logic [5:0] c);
        @(posedge clk_sys);
        pmic_state <= st_off;
        tracking_mode_select <= t;
        programmed_default_setpoint <= c;
        repeat (2) @(posedge clk_sys);
        pmic_state <= st_run;
        pass(3);
    endtask

    // Watchdog, far beyond the 1450 or so cycles the run needs
    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        stop_test();
    end

    initial begin
        rst_n = 1'b0;
        pmic_state = st_off;
        programmed_default_setpoint = 6'h00;
        tracking_mode_select = 1'b0;
        processor_reset_out_n = 1'b1;
        transition_speed_bit = 1'b0;
        hs_ilim_raw = 1'b0;
        ls_ilim_raw = 1'b0;
        switch_cycle_start = 1'b0;
        hs_status_clr = 1'b0;
        ls_status_clr = 1'b0;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        // Startup copy and decode of every table row
        foreach (rows[i]) begin
            {trk, code, exp_v} = rows[i];
            start(trk, code);
            chk("run", {3'h0, run_setpoint}, {3'h0, code});
            chk("standby", {3'h0, standby_setpoint}, {3'h0, code});
            chk("sleep", {3'h0, sleep_setpoint}, {3'h0, code});
            chk("target", target_code, exp_v);
        end
        // Writes taken, then dropped with the processor in reset and with no field
        start(1'b0, 6'h00);
        u_host.wr(sel_standby, 6'h05);
        u_host.wr(sel_sleep, 6'h0a);
        chk("standby", {3'h0, standby_setpoint}, 9'h005);
        chk("sleep", {3'h0, sleep_setpoint}, 9'h00a);
        chk("refused", {8'h00, host_wr_refused}, 9'h000);
        @(posedge clk_sys);
        processor_reset_out_n <= 1'b0;
        u_host.wr(sel_run, 6'h3f);
        chk("refused", {8'h00, host_wr_refused}, 9'h001);
        chk("run", {3'h0, run_setpoint}, 9'h000);
        @(posedge clk_sys);
        processor_reset_out_n <= 1'b1;
        u_host.wr(sel_none, 6'h3f);
        chk("refused", {8'h00, host_wr_refused}, 9'h001);
        // Standby ramps five fast steps, then sleep five slow ones
        @(posedge clk_sys);
        pmic_state <= st_standby;
        pass(3);
        chk("target", target_code, 9'h035);
        pass(200);
        chk("ref", ref_code, 9'h032);
        chk("busy", {8'h00, ramp_busy}, 9'h001);
        pass(220);
        chk("ref", ref_code, 9'h035);
        chk("busy", {8'h00, ramp_busy}, 9'h000);
        @(posedge clk_sys);
        transition_speed_bit <= 1'b1;
        pmic_state <= st_sleep;
        pass(403);
        chk("ref", ref_code, 9'h037);
        pass(450);
        chk("ref", ref_code, 9'h03a);
        // Both limits hit; the low side has a gap that restarts its debounce
        @(posedge clk_sys);
        hs_ilim_raw <= 1'b1;
        ls_ilim_raw <= 1'b1;
        repeat (DEB / 2) @(posedge clk_sys);
        ls_ilim_raw <= 1'b0;
        repeat (3) @(posedge clk_sys);
        ls_ilim_raw <= 1'b1;
        switch_cycle_start <= 1'b1;
        @(posedge clk_sys);
        switch_cycle_start <= 1'b0;
        #1;
        chk("hs_status", {8'h00, hs_ilim_status}, 9'h000);
        chk("hs_off", {8'h00, hs_switch_off}, 9'h001);
        pass(DEB - 7);
        chk("hs_status", {8'h00, hs_ilim_status}, 9'h001);
        chk("ls_status", {8'h00, ls_ilim_status}, 9'h000);
        chk("ls_sense", {8'h00, ls_ilim_sense}, 9'h001);
        chk("ls_off", {8'h00, ls_switch_off}, 9'h001);
        @(posedge clk_sys);
        hs_ilim_raw <= 1'b0;
        ls_ilim_raw <= 1'b0;
        repeat (8) @(posedge clk_sys);
        switch_cycle_start <= 1'b1;
        @(posedge clk_sys);
        switch_cycle_start <= 1'b0;
        pass(1);
        chk("hs_sense", {8'h00, hs_ilim_sense}, 9'h000);
        chk("offs", {7'h00, hs_switch_off, ls_switch_off}, 9'h000);
        chk("hs_status", {8'h00, hs_ilim_status}, 9'h001);
        @(posedge clk_sys);
        hs_status_clr <= 1'b1;
        @(posedge clk_sys);
        hs_status_clr <= 1'b0;
        pass(1);
        chk("hs_status", {8'h00, hs_ilim_status}, 9'h000);
        // Fixed table in sleep; loaded fields then give the reset a real value to clear
        start(1'b1, 6'h04);
        @(posedge clk_sys);
        pmic_state <= st_sleep;
        pass(3);
        chk("target", target_code, 9'h090);
        chk("ref", ref_code, 9'h090);
        // Reset in mid-run clears fields and reference
        @(posedge clk_sys);
        rst_n <= 1'b0;
        pass(2);
        chk("run", {3'h0, run_setpoint}, 9'h000);
        chk("ref", ref_code, 9'h000);
        stop_test();
    end
endmodule
